// ### wdg_top.sv
`timescale 1ns/1ps
// Function
// - Counter advances only on low-frequency oscillator ticks.
// - Dedicated 16-bit prescaler precedes time-out.
// - Shared 8-bit prescaler serves watchdog or timer.
// - Time-out spans about 1 ms to 268 s.
// - Reset loads period 0100, soft enable off.
// - Watchdog held cleared while start-up timer counts.
// - Fuse set runs watchdog, soft enable ignored.
// - Fuse clear lets soft enable start/stop.
// - Clear when disabled, instruction, oscillator fail, wake.
// - Crystal wake keeps counter cleared until start-up ends.
// - Period field selects 1:32 to 1:65536.
// - Bit 0 is soft enable, resets zero.
// - Control bits 7 to 5 read zero.
// - Stable flag ignores watchdog use of oscillator.
// - Sleep entered only by sleep instruction.
// - Sleep entry clears counter, counting continues.
// - Sleep entry clears power-down, sets time-out flag.
// - Sleep entry switches main oscillator driver off.
// - Port pins keep drive state during sleep.
// - Watchdog reset never drives master clear low.
// - Any wake from sleep clears the counter.
// - Watchdog wake clears time-out flag, execution continues.
module wdg_top
  import wdg_pkg::*;
(
  // Clock, reset and enable.
  input  wire  logic         pclk,
  input  wire  logic         presetn,
  input  wire  logic         clk_en,
  // APB slave.
  input  wire  logic         psel,
  input  wire  logic         penable,
  input  wire  logic         pwrite,
  input  wire  logic [7:0]   paddr,
  input  wire  logic [31:0]  pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // Configuration and oscillator.
  input  wire  logic         watchdog_fuse_enable,
  input  wire  wdg_clk_src_t sys_clk_src,
  input  wire  logic         low_freq_internal_osc,
  input  wire  logic         lfo_other_request,
  input  wire  logic         lfo_ready,
  // Core events.
  input  wire  wdg_evt_t     evt,
  // Port pins before the sleep hold.
  input  wire  logic [7:0]   port_out_in,
  input  wire  logic [7:0]   port_oe_in,
  // Results.
  output wdg_flags_t         flags,
  output logic               watchdog_reset,
  output logic               watchdog_wake,
  output logic               asleep,
  output logic               main_osc_drive_en,
  output logic               lfo_enable,
  output logic               low_osc_stable_flag,
  output logic               timer_owns_prescaler,
  output logic [7:0]         port_out,
  output logic [7:0]         port_oe,
  output logic               master_clear_pin_out,
  output logic               master_clear_pin_oe
);

  logic [4:0]  ctrl_q;
  logic [7:0]  option_q;
  logic [15:0] pre_q;
  logic [7:0]  post_q;
  logic        hold_q;
  logic        asleep_q;
  logic        to_q;
  logic        pd_q;
  logic        rst_q;
  logic        wake_q;
  logic        osc_q;
  logic        lfo_en_q;
  logic        lts_q;
  logic [7:0]  port_out_q;
  logic [7:0]  port_oe_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  logic        wdt_en;
  logic        crystal;
  logic        sleep_go;
  logic        wake_irq;
  logic        clr_cnt;
  logic [3:0]  ps_sel;
  logic [16:0] ratio;
  logic [15:0] pre_last;
  logic        pre_term;
  logic [7:0]  post_last;
  logic        timeout;
  logic        bus_acc;
  logic        bus_wr;
  logic        addr_ok;

  assign wdt_en   = watchdog_fuse_enable | ctrl_q[WDG_SOFT_EN_BIT];
  assign crystal  = (sys_clk_src == WDG_CLK_XT) ||
                    (sys_clk_src == WDG_CLK_HS) ||
                    (sys_clk_src == WDG_CLK_LP);
  assign sleep_go = evt.sleep_instruction & ~asleep_q;
  assign wake_irq = evt.wake_interrupt & asleep_q & ~sleep_go;

  // Selected ratio of the dedicated prescaler; reserved codes act as the
  // largest ratio.
  assign ps_sel   = (ctrl_q[WDG_PS_MSB:WDG_PS_LSB] > WDG_PS_MAX) ?
                    WDG_PS_MAX : ctrl_q[WDG_PS_MSB:WDG_PS_LSB];
  assign ratio    = WDG_BASE_RATIO << ps_sel;
  assign pre_last = 16'(ratio - 17'h00001);
  assign pre_term = low_freq_internal_osc && (pre_q == pre_last);

  // The shared prescaler adds 1:1 to 1:128 only when assigned here.
  assign post_last = 8'((9'h001 << option_q[WDG_SPS_MSB:WDG_SPS_LSB]) -
                        9'h001);
  assign timeout  = pre_term &&
                    (~option_q[WDG_PSA_BIT] || (post_q == post_last));

  // Everything that holds the ripple counter and prescalers at zero.
  assign clr_cnt  = ~wdt_en
                  | evt.clear_watchdog_instruction
                  | evt.osc_fail
                  | evt.oscillator_startup_timer
                  | hold_q
                  | sleep_go
                  | wake_irq;
  // A watchdog wake clears both counters through the terminal count.

  assign bus_acc  = psel & penable & pready_q;
  assign bus_wr   = bus_acc & pwrite & ~pslverr_q;
  assign addr_ok  = (paddr == WDG_CTRL_OFS) || (paddr == WDG_OPTION_OFS) ||
                    (paddr == WDG_STATUS_OFS);

  // Dedicated 16-bit prescaler.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 16'h0000;
    end else if (clk_en) begin
      if (clr_cnt || pre_term) begin
        pre_q <= 16'h0000;
      end else if (low_freq_internal_osc) begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end

  // Shared 8-bit prescaler, counting for the watchdog only when assigned.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_q <= 8'h00;
    end else if (clk_en) begin
      if (clr_cnt || timeout || ~option_q[WDG_PSA_BIT]) begin
        post_q <= 8'h00;
      end else if (pre_term) begin
        post_q <= post_q + 8'h01;
      end
    end
  end

  // Crystal wake keeps the watchdog cleared until start-up completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
    end else if (clk_en) begin
      if ((wake_irq || (timeout && asleep_q && !clr_cnt)) && crystal) begin
        hold_q <= 1'b1;
      end else if (evt.startup_done) begin
        hold_q <= 1'b0;
      end
    end
  end

  // Sleep state and main oscillator driver.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asleep_q <= 1'b0;
      osc_q    <= 1'b1;
    end else if (clk_en) begin
      if (sleep_go) begin
        asleep_q <= 1'b1;
        osc_q    <= 1'b0;
      end else if (wake_irq || (timeout && asleep_q && !clr_cnt)) begin
        asleep_q <= 1'b0;
        osc_q    <= 1'b1;
      end
    end
  end

  // Status flags; power-on leaves both set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (clk_en) begin
      if (sleep_go) begin
        to_q <= 1'b1;
        pd_q <= 1'b0;
      end else if (evt.clear_watchdog_instruction) begin
        to_q <= 1'b1;
        pd_q <= 1'b1;
      end else if (timeout && !clr_cnt) begin
        to_q <= 1'b0;
      end
    end
  end

  // Reset and wake pulses from a time-out.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q  <= 1'b0;
      wake_q <= 1'b0;
    end else if (clk_en) begin
      rst_q  <= timeout & ~clr_cnt & ~asleep_q;
      wake_q <= timeout & ~clr_cnt & asleep_q;
    end
  end

  // Oscillator request and its stable flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfo_en_q <= 1'b0;
      lts_q    <= 1'b0;
    end else if (clk_en) begin
      lfo_en_q <= wdt_en | lfo_other_request;
      lts_q    <= lfo_other_request & lfo_ready;
    end
  end

  // Port drive state follows the core while awake and freezes in sleep.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out_q <= 8'h00;
      port_oe_q  <= 8'h00;
    end else if (clk_en && !asleep_q && !sleep_go) begin
      port_out_q <= port_out_in;
      port_oe_q  <= port_oe_in;
    end
  end

  // Registers written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= WDG_CTRL_RST;
      option_q <= WDG_OPTION_RST;
    end else if (clk_en && bus_wr) begin
      if (paddr == WDG_CTRL_OFS) begin
        ctrl_q <= pwdata[4:0];
      end
      if (paddr == WDG_OPTION_OFS) begin
        option_q <= pwdata[7:0];
      end
    end
  end

  // APB answer: one wait cycle, then ready for one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      if (psel && penable && !pready_q) begin
        pready_q  <= 1'b1;
        pslverr_q <= ~addr_ok;
        prdata_q  <= 32'h00000000;
        if (!pwrite) begin
          case (paddr)
            WDG_CTRL_OFS: begin
              prdata_q <= {27'h0000000, ctrl_q};
            end
            WDG_OPTION_OFS: begin
              prdata_q <= {24'h000000, option_q};
            end
            WDG_STATUS_OFS: begin
              prdata_q <= {27'h0000000, to_q, pd_q, 3'h0};
            end
            default: begin
              prdata_q <= 32'h00000000;
            end
          endcase
        end
      end else begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  assign pready               = pready_q;
  assign prdata               = prdata_q;
  assign pslverr              = pslverr_q;
  assign flags                = '{timeout_flag: to_q, power_down_flag: pd_q};
  assign watchdog_reset       = rst_q;
  assign watchdog_wake        = wake_q;
  assign asleep               = asleep_q;
  assign main_osc_drive_en    = osc_q;
  assign lfo_enable           = lfo_en_q;
  assign low_osc_stable_flag  = lts_q;
  assign timer_owns_prescaler = ~option_q[WDG_PSA_BIT];
  assign port_out             = port_out_q;
  assign port_oe              = port_oe_q;
  // The reset stays internal; the pin is never driven.
  assign master_clear_pin_out = 1'b0;
  assign master_clear_pin_oe  = 1'b0;

endmodule

// ### wdg_pkg.sv
package wdg_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] WDG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] WDG_OPTION_OFS = 8'h04;
  localparam logic [7:0] WDG_STATUS_OFS = 8'h08;

  // Watchdog control fields and reset value.
  localparam int         WDG_SOFT_EN_BIT = 0;
  localparam int         WDG_PS_LSB      = 1;
  localparam int         WDG_PS_MSB      = 4;
  localparam logic [4:0] WDG_CTRL_RST    = 5'h08;

  // Timer option fields and reset value.
  localparam int         WDG_PSA_BIT    = 3;
  localparam int         WDG_SPS_LSB    = 0;
  localparam int         WDG_SPS_MSB    = 2;
  localparam logic [7:0] WDG_OPTION_RST = 8'hFF;

  // Status fields.
  localparam int WDG_PD_BIT = 3;
  localparam int WDG_TO_BIT = 4;

  // Prescale figures.
  localparam logic [16:0] WDG_BASE_RATIO = 17'h00020;
  localparam logic [3:0]  WDG_PS_MAX     = 4'hB;

  // Time base of the watchdog oscillator and the bus clock.
  localparam int WDG_LFO_HZ  = 31000;
  localparam int WDG_PCLK_HZ = 10000000;
  localparam int WDG_PCLK_PER_LFO = WDG_PCLK_HZ / WDG_LFO_HZ;

  // System clock sources.
  typedef enum logic [2:0] {
    WDG_CLK_LP     = 3'h0,
    WDG_CLK_XT     = 3'h1,
    WDG_CLK_HS     = 3'h2,
    WDG_CLK_EXTERNAL_RC_CLOCK  = 3'h3,
    WDG_CLK_INTERNAL_OSCILLATOR = 3'h4,
    WDG_CLK_EXTERNAL_CLOCK_INPUT = 3'h5,
    WDG_CLK_SECOSC = 3'h6
  } wdg_clk_src_t;

  // Core events seen by the watchdog, each a one-cycle pulse but the
  // start-up timer activity, which is a level.
  typedef struct packed {
    logic clear_watchdog_instruction;
    logic sleep_instruction;
    logic wake_interrupt;
    logic osc_fail;
    logic oscillator_startup_timer;
    logic startup_done;
  } wdg_evt_t;

  // Power state flags as seen in the core status register.
  typedef struct packed {
    logic timeout_flag;
    logic power_down_flag;
  } wdg_flags_t;

endpackage

// ### wdg_sva.sv
`timescale 1ns/1ps
module wdg_sva
  import wdg_pkg::*;
(
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       clk_en,
  // Watched signals.
  input wire logic       lfo_other_request,
  input wire logic       lfo_ready,
  input wire wdg_evt_t   evt,
  input wire logic [7:0] port_out_in,
  input wire wdg_flags_t flags,
  input wire logic       watchdog_reset,
  input wire logic       watchdog_wake,
  input wire logic       asleep,
  input wire logic       main_osc_drive_en,
  input wire logic       low_osc_stable_flag,
  input wire logic [7:0] port_out,
  input wire logic       master_clear_pin_out,
  input wire logic       master_clear_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_master_clear_pin_released: assert property (
    !master_clear_pin_oe && !master_clear_pin_out)
    else $error("Master clear driven.");
  a_sleep_entry: assert property (
    clk_en && evt.sleep_instruction && !asleep |=>
    asleep && flags == 2'b10 && !main_osc_drive_en)
    else $error("Bad sleep entry.");
  a_sleep_cause: assert property (
    $rose(asleep) |-> $past(evt.sleep_instruction))
    else $error("Sleep without instruction.");
  a_clear_flags: assert property (
    clk_en && evt.clear_watchdog_instruction && !evt.sleep_instruction
    && !asleep |=> flags == 2'b11)
    else $error("Clear did not set flags.");
  a_reset_pulse: assert property (
    watchdog_reset |-> (!flags.timeout_flag && !asleep) ##1 !watchdog_reset)
    else $error("Bad watchdog reset.");
  a_wake_pulse: assert property (
    watchdog_wake |-> $past(asleep) && !asleep && !flags.timeout_flag)
    else $error("Bad watchdog wake.");
  a_ports_frozen: assert property (
    asleep && $past(asleep) |-> $stable(port_out))
    else $error("Port changed in sleep.");
  a_ports_follow: assert property (
    $past(presetn) && $past(clk_en) && !asleep && !$past(asleep)
    |-> port_out == $past(port_out_in))
    else $error("Port did not follow.");
  a_lts_only_other: assert property (
    $past(presetn) && $past(clk_en) |->
    low_osc_stable_flag == ($past(lfo_other_request) && $past(lfo_ready)))
    else $error("Stable flag wrong.");
  a_startup_hold: assert property (
    evt.oscillator_startup_timer && $past(evt.oscillator_startup_timer)
    |=> !watchdog_reset && !watchdog_wake)
    else $error("Time-out during start-up.");
endmodule

bind wdg_top wdg_sva i_wdg_sva (
  .pclk, .presetn, .clk_en, .lfo_other_request, .lfo_ready, .evt,
  .port_out_in, .flags, .watchdog_reset, .watchdog_wake, .asleep,
  .main_osc_drive_en, .low_osc_stable_flag, .port_out,
  .master_clear_pin_out, .master_clear_pin_oe
);

// ### tb_watchdog_with_sleep_entry.sv
`timescale 1ns/1ps
module tb_watchdog_with_sleep_entry
  import wdg_pkg::*;
;
  logic         pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]   paddr = '0, port_out_in = '0, port_oe_in = '0;
  logic [31:0]  pwdata = '0, prdata, rs = 32'h3A;
  logic         pready, pslverr, fuse = 1'b0, lfo = 1'b0, lfo_req = 1'b0;
  wdg_clk_src_t src = WDG_CLK_INTERNAL_OSCILLATOR;
  wdg_evt_t     evt = '0;
  wdg_flags_t   flags;
  logic         wd_rst, wd_wake, asleep, osc_en, tmr_own, lfo_en;
  logic [7:0]   port_out, port_oe;
  logic [15:0]  pv;
  logic [32:0]  q[$];
  int           n_mismatch = 0, n_compared = 0, n_to = 0, c;

  wdg_top i_wdg_top (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .watchdog_fuse_enable(fuse),
    .sys_clk_src(src), .low_freq_internal_osc(lfo),
    .lfo_other_request(lfo_req), .lfo_ready(1'b1), .evt, .port_out_in,
    .port_oe_in, .flags, .watchdog_reset(wd_rst), .watchdog_wake(wd_wake),
    .asleep, .main_osc_drive_en(osc_en), .lfo_enable(lfo_en),
    .low_osc_stable_flag(), .timer_owns_prescaler(tmr_own), .port_out,
    .port_oe, .master_clear_pin_out(), .master_clear_pin_oe()
  );

  initial forever #50 pclk = ~pclk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Read answers are checked against the oldest expectation.
  always @(posedge pclk) begin
    if (wd_rst || wd_wake) n_to++;
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata},
        q.pop_front());
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e = '0);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tk(input int n);
    repeat (n) begin
      @(posedge pclk);
      lfo <= 1'b1;
      @(posedge pclk);
      lfo <= 1'b0;
      @(posedge pclk);
    end
    @(negedge pclk);
  endtask

  // Counts ticks until a time-out pulse is seen, at most m.
  task automatic wt(input int m);
    int b;
    b = n_to;
    c = 0;
    while (n_to == b && c < m) begin
      tk(1);
      c++;
    end
  endtask

  task automatic ev(input int i);
    @(posedge pclk);
    evt[i] <= 1'b1;
    @(posedge pclk);
    evt[i] <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, WDG_CTRL_OFS, '0, 33'h008);
    apb(1'b0, WDG_STATUS_OFS, '0, 33'h018);
    apb(1'b0, 8'h0C, '0, 33'h100000000);
    apb(1'b1, WDG_CTRL_OFS, 32'hFFFFFFF0);
    apb(1'b0, WDG_CTRL_OFS, '0, 33'h010);
    apb(1'b1, WDG_OPTION_OFS, '0);
    @(negedge pclk);
    chk(tmr_own, 1'b1);
    $display("Register test done");
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, WDG_CTRL_OFS, 32'(2 * p + 1));
      ev(5);
      wt(300);
      chk(c >= (32 << p) && c <= (32 << p) + 1, 1'b1);
    end
    apb(1'b1, WDG_OPTION_OFS, 32'h00000009);
    apb(1'b0, WDG_OPTION_OFS, '0, 33'h009);
    ev(5);
    wt(300);
    chk(c >= 256 && c <= 257, 1'b1);
    apb(1'b1, WDG_OPTION_OFS, '0);
    apb(1'b0, WDG_STATUS_OFS, '0, 33'h008);
    ev(5);
    apb(1'b0, WDG_STATUS_OFS, '0, 33'h018);
    $display("Period test done");
    apb(1'b1, WDG_CTRL_OFS, '0);
    wt(40);
    chk(c, 40);
    chk(lfo_en, 1'b0);
    @(posedge pclk) fuse <= 1'b1;
    ev(5);
    wt(40);
    chk(c >= 32 && c <= 33, 1'b1);
    chk(lfo_en, 1'b1);
    @(posedge pclk) fuse <= 1'b0;
    $display("Enable test done");
    apb(1'b1, WDG_CTRL_OFS, 32'h1);
    apb(1'b0, WDG_CTRL_OFS, '0, 33'h001);
    rs = xs(rs);
    pv = rs[15:0];
    @(posedge pclk) {lfo_req, port_out_in, port_oe_in} <= rs[16:0];
    ev(5);
    ev(4);
    chk({asleep, osc_en}, 2'b10);
    apb(1'b0, WDG_STATUS_OFS, '0, 33'h010);
    rs = xs(rs);
    @(posedge pclk) {port_out_in, port_oe_in} <= rs[15:0];
    repeat (3) @(posedge pclk);
    chk({port_out, port_oe}, pv);
    wt(40);
    chk(c >= 32 && c <= 33, 1'b1);
    chk(asleep, 1'b0);
    apb(1'b0, WDG_STATUS_OFS, '0, 33'h000);
    $display("Sleep test done");
    @(posedge pclk) src <= WDG_CLK_XT;
    ev(4);
    ev(3);
    wt(40);
    chk(c, 40);
    ev(0);
    wt(40);
    chk(c >= 32 && c <= 33, 1'b1);
    @(posedge pclk) evt.oscillator_startup_timer <= 1'b1;
    wt(40);
    chk(c, 40);
    @(posedge pclk) evt.oscillator_startup_timer <= 1'b0;
    wt(20);
    ev(2);
    wt(40);
    chk(c >= 32 && c <= 33, 1'b1);
    $display("Start-up test done");
    stop_test();
  end
endmodule
